// ---- rtl/dsit_pkg.sv ----
package dsit_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned TICK_HZ_125 = 125;
	localparam int unsigned TICK_HZ_500 = 500;
	localparam int unsigned TICK_HZ_1K = 1000;
	localparam int unsigned TICK_HZ_32K = 32000;
	localparam int unsigned RESUME_HZ = 4000;
	localparam int unsigned DIV_W = 20;

	localparam logic [7:0] OFF_CTL24 = 8'h24;
	localparam logic [7:0] OFF_EVT = 8'h60;
	localparam logic [7:0] OFF_IDLE_CNT = 8'h61;
	localparam logic [7:0] OFF_IDLE_INIT = 8'h62;
	localparam logic [7:0] OFF_RES_INIT = 8'h63;
	localparam logic [7:0] OFF_LOCK = 8'h64;
	localparam logic [7:0] OFF_USB_EN = 8'h65;
	localparam logic [7:0] OFF_NMH_EN = 8'h66;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_CTL24 = 5'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	localparam int unsigned TSEL_LO = 4;
	localparam logic [1:0] TSEL_125 = 2'h0;
	localparam logic [1:0] TSEL_500 = 2'h1;
	localparam logic [1:0] TSEL_1K = 2'h2;
	localparam int unsigned LOCK_BIT = 4;

	localparam int unsigned U_APIC_WAKE = 7;
	localparam int unsigned U_PIC_WAKE = 6;
	localparam int unsigned U_PLL_OFF = 5;
	localparam int unsigned U_USB_WAKE = 4;
	localparam int unsigned U_USB_BM = 3;
	localparam int unsigned U_DEV_MODE = 2;
	localparam int unsigned U_USB_D3 = 1;
	localparam int unsigned U_PLL_GATE = 0;

	localparam int unsigned N_HDA_BM = 7;
	localparam int unsigned N_HDA_WAKE = 6;
	localparam int unsigned N_PLL_GATE = 5;
	localparam int unsigned N_PLL_OFF = 4;
	localparam int unsigned N_NM_WAKE = 3;
	localparam int unsigned N_NM_BM = 2;
	localparam int unsigned N_STOP_GRANT_CYCLE_SEL = 1;
	localparam int unsigned N_NM_D3 = 0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_REQ = 2'h1,
		ST_SLEEP = 2'h3,
		ST_RESUME = 2'h2
	} dsit_state_type;
endpackage : dsit_pkg

// ---- rtl/dsit_tick_gen.sv ----
`timescale 1ns/1ps
module dsit_tick_gen #(
	parameter int unsigned W = 20
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] div_i,
	output logic tick_o
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		cnt_d = cnt_q + W'(1);
		tick_d = 1'b0;
		// >= so a shrinking divisor never strands the counter
		if (cnt_q >= div_i - W'(1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
endmodule : dsit_tick_gen

// ---- rtl/dsit_down_cnt.sv ----
`timescale 1ns/1ps
module dsit_down_cnt #(
	parameter int unsigned W = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic load_i,
	input wire logic [W-1:0] init_i,
	input wire logic tick_i,
	output logic [W-1:0] cnt_o,
	output logic zero_o
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		// a reload beats a tick landing in the same cycle
		if (load_i) begin
			cnt_d = init_i;
		end else if (tick_i && cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
		end
	end

	assign cnt_o = cnt_q;
	assign zero_o = (cnt_q == '0);
endmodule : dsit_down_cnt

// ---- rtl/dsit_ctrl.sv ----
`timescale 1ns/1ps
// Function
// - idle timer count readable at 61h as 8-bit read-only value
// - no deep sleep entry until the idle timer has timed out
// - idle timer loads from 8-bit writable initial value at 62h, reset zero
// - 2-bit tick select: 0.125, 0.5, 1 or 32 kHz
// - resume timeout counts 8-bit initial value in 4 kHz periods
// - lock bit set blocks writes to the five-bit field at 24h
// - enabled advanced interrupt controller interrupt wakes from deep sleep
// - enabled legacy interrupt controller event wakes from deep sleep
// - separate enables for USB PHY PLL shutoff and gating in deep sleep
// - enabled USB event wakes from deep sleep
// - enabled USB bus master activity reloads the idle timer
// - enable lets USB device role take part in deep sleep
// - request USB controller D3 and wait for its acknowledge
// - enabled audio bus master activity reloads the idle timer
// - enabled audio event wakes from deep sleep
// - enabled north module event wakes from deep sleep
// - enabled north module bus master activity reloads the idle timer
// - select bit picks stop-grant source: 0 secondary bus, 1 processor
// - request north module D3 and wait for its acknowledge
module dsit_ctrl #(
	parameter int unsigned DIV_125 = dsit_pkg::CLK_HZ / dsit_pkg::TICK_HZ_125,
	parameter int unsigned DIV_500 = dsit_pkg::CLK_HZ / dsit_pkg::TICK_HZ_500,
	parameter int unsigned DIV_1K = dsit_pkg::CLK_HZ / dsit_pkg::TICK_HZ_1K,
	parameter int unsigned DIV_32K = dsit_pkg::CLK_HZ / dsit_pkg::TICK_HZ_32K,
	parameter int unsigned DIV_4K = dsit_pkg::CLK_HZ / dsit_pkg::RESUME_HZ
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic usb_bm_i,
	input wire logic hda_bm_i,
	input wire logic nm_bm_i,
	input wire logic apic_irq_i,
	input wire logic pic_irq_i,
	input wire logic usb_wake_i,
	input wire logic hda_wake_i,
	input wire logic nm_wake_i,
	input wire logic stop_grant_cycle_sbi_i,
	input wire logic stop_grant_cycle_pif_i,
	input wire logic usb_d3_ack_i,
	input wire logic nm_d3_ack_i,
	output logic [7:0] io_rdata_o,
	output logic [4:0] ctl_field_o,
	output logic deep_sleep_o,
	output logic usb_d3_req_o,
	output logic nm_d3_req_o,
	output logic usb_pll_off_o,
	output logic usb_pll_gate_o,
	output logic nm_pll_off_o,
	output logic nm_pll_gate_o,
	output logic usb_dev_sleep_o,
	output logic resume_busy_o,
	output logic idle_expired_o
);
	localparam int unsigned DW = dsit_pkg::DIV_W;

	function automatic logic [DW-1:0] tick_div(input logic [1:0] sel);
		if (sel == dsit_pkg::TSEL_125) begin
			return DW'(DIV_125);
		end else if (sel == dsit_pkg::TSEL_500) begin
			return DW'(DIV_500);
		end else if (sel == dsit_pkg::TSEL_1K) begin
			return DW'(DIV_1K);
		end
		return DW'(DIV_32K);
	endfunction : tick_div

	function automatic logic bm_hit(input logic [7:0] u, input logic [7:0] n,
			input logic ub, input logic hb, input logic nb);
		return (u[dsit_pkg::U_USB_BM] & ub) | (n[dsit_pkg::N_HDA_BM] & hb)
			| (n[dsit_pkg::N_NM_BM] & nb);
	endfunction : bm_hit

	// register file
	logic [7:0] evt_q, evt_d;
	logic [7:0] init_q, init_d;
	logic [7:0] res_q, res_d;
	logic [7:0] lock_q, lock_d;
	logic [7:0] usb_q, usb_d;
	logic [7:0] nmh_q, nmh_d;
	logic [4:0] field_q, field_d;
	logic [7:0] rdata_q, rdata_d;

	logic [7:0] idle_cnt;
	logic idle_zero;
	logic idle_tick;
	logic [7:0] res_cnt;
	logic res_zero;
	logic res_tick;
	logic bm_evt;
	logic wake;
	logic stop_grant_cycle;
	logic res_load;

	always_comb begin
		evt_d = evt_q;
		init_d = init_q;
		res_d = res_q;
		lock_d = lock_q;
		usb_d = usb_q;
		nmh_d = nmh_q;
		field_d = field_q;
		if (io_wr_i) begin
			if (io_addr_i == dsit_pkg::OFF_EVT) begin
				evt_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_IDLE_INIT) begin
				init_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_RES_INIT) begin
				res_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_LOCK) begin
				lock_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_USB_EN) begin
				usb_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_NMH_EN) begin
				nmh_d = io_wdata_i;
			end else if (io_addr_i == dsit_pkg::OFF_CTL24
					&& !lock_q[dsit_pkg::LOCK_BIT]) begin
				field_d = io_wdata_i[4:0];
			end
		end
		rdata_d = rdata_q;
		if (io_rd_i) begin
			if (io_addr_i == dsit_pkg::OFF_EVT) begin
				rdata_d = evt_q;
			end else if (io_addr_i == dsit_pkg::OFF_IDLE_CNT) begin
				rdata_d = idle_cnt;
			end else if (io_addr_i == dsit_pkg::OFF_IDLE_INIT) begin
				rdata_d = init_q;
			end else if (io_addr_i == dsit_pkg::OFF_RES_INIT) begin
				rdata_d = res_q;
			end else if (io_addr_i == dsit_pkg::OFF_LOCK) begin
				rdata_d = lock_q;
			end else if (io_addr_i == dsit_pkg::OFF_USB_EN) begin
				rdata_d = usb_q;
			end else if (io_addr_i == dsit_pkg::OFF_NMH_EN) begin
				rdata_d = nmh_q;
			end else if (io_addr_i == dsit_pkg::OFF_CTL24) begin
				rdata_d = {3'h0, field_q};
			end else begin
				rdata_d = dsit_pkg::RD_UNMAPPED;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_q <= dsit_pkg::RST_BYTE;
			init_q <= dsit_pkg::RST_BYTE;
			res_q <= dsit_pkg::RST_BYTE;
			lock_q <= dsit_pkg::RST_BYTE;
			usb_q <= dsit_pkg::RST_BYTE;
			nmh_q <= dsit_pkg::RST_BYTE;
			field_q <= dsit_pkg::RST_CTL24;
			rdata_q <= dsit_pkg::RST_BYTE;
		end else if (ce_i) begin
			evt_q <= evt_d;
			init_q <= init_d;
			res_q <= res_d;
			lock_q <= lock_d;
			usb_q <= usb_d;
			nmh_q <= nmh_d;
			field_q <= field_d;
			rdata_q <= rdata_d;
		end
	end

	// timers
	dsit_tick_gen #(.W(DW)) u_idle_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.div_i(tick_div(evt_q[dsit_pkg::TSEL_LO +: 2])),
		.tick_o(idle_tick)
	);

	dsit_tick_gen #(.W(DW)) u_res_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.div_i(DW'(DIV_4K)),
		.tick_o(res_tick)
	);

	assign bm_evt = bm_hit(usb_q, nmh_q, usb_bm_i, hda_bm_i, nm_bm_i);

	dsit_down_cnt #(.W(8)) u_idle_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.load_i(bm_evt),
		.init_i(init_q),
		.tick_i(idle_tick),
		.cnt_o(idle_cnt),
		.zero_o(idle_zero)
	);

	dsit_down_cnt #(.W(8)) u_res_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.load_i(res_load),
		.init_i(res_q),
		.tick_i(res_tick),
		.cnt_o(res_cnt),
		.zero_o(res_zero)
	);

	// wake and entry sources
	assign wake = (usb_q[dsit_pkg::U_APIC_WAKE] & apic_irq_i)
		| (usb_q[dsit_pkg::U_PIC_WAKE] & pic_irq_i)
		| (usb_q[dsit_pkg::U_USB_WAKE] & usb_wake_i)
		| (nmh_q[dsit_pkg::N_HDA_WAKE] & hda_wake_i)
		| (nmh_q[dsit_pkg::N_NM_WAKE] & nm_wake_i);
	assign stop_grant_cycle = nmh_q[dsit_pkg::N_STOP_GRANT_CYCLE_SEL] ? stop_grant_cycle_pif_i : stop_grant_cycle_sbi_i;

	// sequencer
	dsit_pkg::dsit_state_type state_q, state_d;
	logic sleep_q, sleep_d;
	logic usb_req_q, usb_req_d;
	logic nm_req_q, nm_req_d;
	logic upoff_q, upoff_d;
	logic upgate_q, upgate_d;
	logic npoff_q, npoff_d;
	logic npgate_q, npgate_d;
	logic udev_q, udev_d;
	logic resb_q, resb_d;
	logic idlex_q, idlex_d;
	logic acks_ok;

	// disabled handshakes count as already acknowledged
	assign acks_ok = (!usb_q[dsit_pkg::U_USB_D3] || usb_d3_ack_i)
		&& (!nmh_q[dsit_pkg::N_NM_D3] || nm_d3_ack_i);
	assign res_load = (state_q == dsit_pkg::ST_SLEEP) && wake;

	always_comb begin
		state_d = state_q;
		case (state_q)
			dsit_pkg::ST_IDLE: begin
				// a reload in this cycle means activity: stay out
				if (stop_grant_cycle && idle_zero && !bm_evt) begin
					state_d = dsit_pkg::ST_REQ;
				end
			end
			dsit_pkg::ST_REQ: begin
				if (bm_evt || wake) begin
					state_d = dsit_pkg::ST_IDLE;
				end else if (acks_ok) begin
					state_d = dsit_pkg::ST_SLEEP;
				end
			end
			dsit_pkg::ST_SLEEP: begin
				if (wake) begin
					state_d = dsit_pkg::ST_RESUME;
				end
			end
			dsit_pkg::ST_RESUME: begin
				if (res_zero) begin
					state_d = dsit_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = dsit_pkg::ST_IDLE;
			end
		endcase
		sleep_d = (state_d == dsit_pkg::ST_SLEEP);
		usb_req_d = usb_q[dsit_pkg::U_USB_D3] && (state_d == dsit_pkg::ST_REQ || sleep_d);
		nm_req_d = nmh_q[dsit_pkg::N_NM_D3] && (state_d == dsit_pkg::ST_REQ || sleep_d);
		upoff_d = usb_q[dsit_pkg::U_PLL_OFF] && sleep_d;
		upgate_d = usb_q[dsit_pkg::U_PLL_GATE] && sleep_d;
		npoff_d = nmh_q[dsit_pkg::N_PLL_OFF] && sleep_d;
		npgate_d = nmh_q[dsit_pkg::N_PLL_GATE] && sleep_d;
		udev_d = usb_q[dsit_pkg::U_DEV_MODE] && sleep_d;
		resb_d = (state_d == dsit_pkg::ST_RESUME);
		idlex_d = idle_zero;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= dsit_pkg::ST_IDLE;
			sleep_q <= 1'b0;
			usb_req_q <= 1'b0;
			nm_req_q <= 1'b0;
			upoff_q <= 1'b0;
			upgate_q <= 1'b0;
			npoff_q <= 1'b0;
			npgate_q <= 1'b0;
			udev_q <= 1'b0;
			resb_q <= 1'b0;
			idlex_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			sleep_q <= sleep_d;
			usb_req_q <= usb_req_d;
			nm_req_q <= nm_req_d;
			upoff_q <= upoff_d;
			upgate_q <= upgate_d;
			npoff_q <= npoff_d;
			npgate_q <= npgate_d;
			udev_q <= udev_d;
			resb_q <= resb_d;
			idlex_q <= idlex_d;
		end
	end

	assign io_rdata_o = rdata_q;
	assign ctl_field_o = field_q;
	assign deep_sleep_o = sleep_q;
	assign usb_d3_req_o = usb_req_q;
	assign nm_d3_req_o = nm_req_q;
	assign usb_pll_off_o = upoff_q;
	assign usb_pll_gate_o = upgate_q;
	assign nm_pll_off_o = npoff_q;
	assign nm_pll_gate_o = npgate_q;
	assign usb_dev_sleep_o = udev_q;
	assign resume_busy_o = resb_q;
	assign idle_expired_o = idlex_q;

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_count_read: assert property (ce_i && io_rd_i && io_addr_i == dsit_pkg::OFF_IDLE_CNT
		|=> io_rdata_o == $past(idle_cnt)) else $error("idle count read wrong");
	a_no_early_entry: assert property (state_q != dsit_pkg::ST_REQ ##1
		state_q == dsit_pkg::ST_REQ |-> $past(idle_cnt) == 8'h00)
		else $error("entry before idle timeout");
	a_lock_blocks: assert property (ce_i && io_wr_i && io_addr_i == dsit_pkg::OFF_CTL24
		&& lock_q[dsit_pkg::LOCK_BIT] |=> $stable(ctl_field_o))
		else $error("locked field changed");
	a_unlock_write: assert property (ce_i && io_wr_i && io_addr_i == dsit_pkg::OFF_CTL24
		&& !lock_q[dsit_pkg::LOCK_BIT] |=> ctl_field_o == $past(io_wdata_i[4:0]))
		else $error("unlocked field write lost");
	a_usb_bm_reload: assert property (ce_i && usb_bm_i && usb_q[dsit_pkg::U_USB_BM]
		|=> idle_cnt == $past(init_q)) else $error("usb activity no reload");
	a_hda_bm_reload: assert property (ce_i && hda_bm_i && nmh_q[dsit_pkg::N_HDA_BM]
		|=> idle_cnt == $past(init_q)) else $error("audio activity no reload");
	a_nm_bm_reload: assert property (ce_i && nm_bm_i && nmh_q[dsit_pkg::N_NM_BM]
		|=> idle_cnt == $past(init_q)) else $error("nm activity no reload");
	a_idle_hold: assert property (!(ce_i && (bm_evt || idle_tick)) |=> $stable(idle_cnt))
		else $error("idle count moved without cause");
	a_apic_wake: assert property (ce_i && state_q == dsit_pkg::ST_SLEEP && apic_irq_i
		&& usb_q[dsit_pkg::U_APIC_WAKE] |=> state_q == dsit_pkg::ST_RESUME ##1 resume_busy_o)
		else $error("apic wake missed");
	a_pic_wake: assert property (ce_i && state_q == dsit_pkg::ST_SLEEP && pic_irq_i
		&& usb_q[dsit_pkg::U_PIC_WAKE] |=> !deep_sleep_o) else $error("pic wake missed");
	a_usb_wake: assert property (ce_i && state_q == dsit_pkg::ST_SLEEP && usb_wake_i
		&& usb_q[dsit_pkg::U_USB_WAKE] |=> !deep_sleep_o) else $error("usb wake missed");
	a_hda_wake: assert property (ce_i && state_q == dsit_pkg::ST_SLEEP && hda_wake_i
		&& nmh_q[dsit_pkg::N_HDA_WAKE] |=> !deep_sleep_o) else $error("audio wake missed");
	a_nm_wake: assert property (ce_i && state_q == dsit_pkg::ST_SLEEP && nm_wake_i
		&& nmh_q[dsit_pkg::N_NM_WAKE] |=> !deep_sleep_o) else $error("nm wake missed");
	a_pll_in_sleep: assert property ((usb_pll_off_o || usb_pll_gate_o) |-> deep_sleep_o)
		else $error("usb pll action outside sleep");
	a_usb_d3_wait: assert property (ce_i && state_q == dsit_pkg::ST_REQ
		&& usb_q[dsit_pkg::U_USB_D3] && !usb_d3_ack_i |=> !deep_sleep_o && usb_d3_req_o || !usb_q[dsit_pkg::U_USB_D3])
		else $error("sleep without usb ack");
	a_nm_d3_wait: assert property (ce_i && state_q == dsit_pkg::ST_REQ
		&& nmh_q[dsit_pkg::N_NM_D3] && !nm_d3_ack_i |=> state_q != dsit_pkg::ST_SLEEP)
		else $error("sleep without nm ack");
	a_stop_grant_cycle_src: assert property (state_q == dsit_pkg::ST_IDLE
		&& state_d == dsit_pkg::ST_REQ |-> (nmh_q[dsit_pkg::N_STOP_GRANT_CYCLE_SEL]
		? stop_grant_cycle_pif_i : stop_grant_cycle_sbi_i)) else $error("entry on wrong stop-grant source");
	a_resume_hold: assert property (ce_i && state_q == dsit_pkg::ST_RESUME && res_cnt != 8'h00
		|=> state_q == dsit_pkg::ST_RESUME) else $error("resume ended early");

	c_enter_sleep: cover property (state_q == dsit_pkg::ST_REQ ##1 deep_sleep_o);
	c_wake: cover property (deep_sleep_o ##1 resume_busy_o);
	c_resume_done: cover property (resume_busy_o ##1 state_q == dsit_pkg::ST_IDLE);
	c_lock_write: cover property (io_wr_i && io_addr_i == dsit_pkg::OFF_CTL24
		&& lock_q[dsit_pkg::LOCK_BIT]);
endmodule : dsit_ctrl

// ---- tb/dsit_far_model.sv ----
`timescale 1ns/1ps
module dsit_far_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] dly_i,
	input wire logic usb_req_i,
	input wire logic nm_req_i,
	output logic usb_ack_o,
	output logic nm_ack_o
);
	logic [3:0] usb_cnt_q;
	logic [3:0] nm_cnt_q;
	// ack follows the request after dly_i cycles and drops with it, so a slow ack is seen
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			usb_cnt_q <= 4'h0;
			nm_cnt_q <= 4'h0;
		end else begin
			usb_cnt_q <= !usb_req_i ? 4'h0 : usb_cnt_q + ((usb_cnt_q != dly_i) ? 4'h1 : 4'h0);
			nm_cnt_q <= !nm_req_i ? 4'h0 : nm_cnt_q + ((nm_cnt_q != dly_i) ? 4'h1 : 4'h0);
		end
	end
	assign usb_ack_o = usb_req_i && (usb_cnt_q == dly_i);
	assign nm_ack_o = nm_req_i && (nm_cnt_q == dly_i);
endmodule : dsit_far_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic [7:0] io_addr_i = 8'h00;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	// 0..2 bus masters, 3..7 wake sources, 8 secondary bus and 9 processor stop-grant
	logic [9:0] ev = 10'h000;
	logic [3:0] dly = 4'h0;
	logic usb_ack, nm_ack, usb_req, nm_req;
	logic [7:0] rdata;
	logic [4:0] field;
	logic deep, busy, expd, u_off, u_gate, n_off, n_gate, dev;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;

	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	dsit_ctrl #(.DIV_125(4), .DIV_500(5), .DIV_1K(6), .DIV_32K(3), .DIV_4K(4)) i_dsit_ctrl (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .io_addr_i(io_addr_i),
		.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
		.usb_bm_i(ev[0]), .hda_bm_i(ev[1]), .nm_bm_i(ev[2]), .apic_irq_i(ev[3]),
		.pic_irq_i(ev[4]), .usb_wake_i(ev[5]), .hda_wake_i(ev[6]), .nm_wake_i(ev[7]),
		.stop_grant_cycle_sbi_i(ev[8]), .stop_grant_cycle_pif_i(ev[9]), .usb_d3_ack_i(usb_ack),
		.nm_d3_ack_i(nm_ack), .io_rdata_o(rdata), .ctl_field_o(field), .deep_sleep_o(deep),
		.usb_d3_req_o(usb_req), .nm_d3_req_o(nm_req), .usb_pll_off_o(u_off),
		.usb_pll_gate_o(u_gate), .nm_pll_off_o(n_off), .nm_pll_gate_o(n_gate),
		.usb_dev_sleep_o(dev), .resume_busy_o(busy), .idle_expired_o(expd));

	dsit_far_model i_dsit_far_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dly_i(dly),
		.usb_req_i(usb_req), .nm_req_i(nm_req), .usb_ack_o(usb_ack), .nm_ack_o(nm_ack));

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge ref_clk_i);
		io_wr_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge ref_clk_i);
		io_rd_i = 1'b0;
		chk8(rdata, exp);
	endtask : rd

	task automatic pulse(input int k);
		@(negedge ref_clk_i);
		ev[k] = 1'b1;
		@(negedge ref_clk_i);
		ev[k] = 1'b0;
	endtask : pulse

	function automatic logic sig(input int k);
		case (k)
			0: return expd;
			1: return deep;
			default: return ~busy;
		endcase
	endfunction : sig

	// bounded wait; n returns the cycles spent
	task automatic wait_hi(input int k, input int lim, output int n);
		n = 0;
		while (sig(k) !== 1'b1 && n < lim) begin
			@(negedge ref_clk_i);
			n++;
		end
	endtask : wait_hi

	task automatic t_regs();
		logic [7:0] offs [9] = '{8'h24, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h70};
		foreach (offs[i]) rd(offs[i], 8'h00);
		for (int i = 3; i < 8; i++) begin
			wr(offs[i], 8'ha5 ^ 8'(i));
			rd(offs[i], 8'ha5 ^ 8'(i));
			wr(offs[i], 8'h00);
		end
		wr(8'h61, 8'hff);
		rd(8'h61, 8'h00);
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h00);
	endtask : t_regs

	// a write while the clock enable is low must leave the idle initial value at 62h frozen
	task automatic t_ce();
		@(negedge ref_clk_i);
		ce = 1'b0;
		wr(8'h62, 8'h55);
		ce = 1'b1;
		rd(8'h62, 8'h00);
	endtask : t_ce

	task automatic t_lock();
		wr(8'h24, 8'h1f);
		chk8({3'h0, field}, 8'h1f);
		wr(8'h64, 8'h10);
		wr(8'h24, 8'h0a);
		rd(8'h24, 8'h1f);
		wr(8'h64, 8'h00);
		wr(8'h24, 8'h0a);
		rd(8'h24, 8'h0a);
	endtask : t_lock

	task automatic t_idle();
		int divs [4] = '{4, 5, 6, 3};
		int n;
		wr(8'h65, 8'h08);
		wr(8'h62, 8'h06);
		for (int c = 0; c < 4; c++) begin
			wr(8'h60, 8'(c << 4));
			pulse(0);
			cyc(1);
			wait_hi(0, 400, n);
			chk1(n >= 5 * divs[c] - 2 && n <= 6 * divs[c] + 3, 1'b1);
			rd(8'h61, 8'h00);
		end
	endtask : t_idle

	task automatic t_bm();
		logic [7:0] regs [3] = '{8'h65, 8'h66, 8'h66};
		logic [7:0] bits [3] = '{8'h08, 8'h80, 8'h04};
		int n;
		wr(8'h60, 8'h30);
		wr(8'h62, 8'h04);
		for (int s = 0; s < 3; s++) begin
			wr(8'h65, 8'h00);
			wr(8'h66, 8'h00);
			pulse(s);
			cyc(2);
			chk1(expd, 1'b1);
			wr(regs[s], bits[s]);
			pulse(s);
			cyc(2);
			chk1(expd, 1'b0);
			wait_hi(0, 100, n);
		end
	endtask : t_bm

	task automatic t_block();
		int n;
		wr(8'h65, 8'h0a);
		wr(8'h66, 8'h00);
		wr(8'h62, 8'h20);
		pulse(0);
		pulse(8);
		cyc(3);
		chk1(usb_req || deep, 1'b0);
		wait_hi(0, 200, n);
	endtask : t_block

	task automatic t_wake();
		logic [7:0] ue [5] = '{8'h80, 8'h40, 8'h10, 8'h00, 8'h00};
		logic [7:0] ne [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h08};
		logic [7:0] u;
		logic [7:0] m;
		int n;
		wr(8'h63, 8'h02);
		for (int k = 0; k < 5; k++) begin
			// odd passes drop some plant enables and use the processor stop-grant
			u = 8'h27 ^ (k[0] ? 8'h24 : 8'h00) | ue[k];
			m = 8'h31 ^ (k[0] ? 8'h30 : 8'h00) | ne[k] | {6'h00, k[0], 1'b0};
			dly = 4'(k * 2);
			wr(8'h65, u);
			wr(8'h66, m);
			pulse(k[0] ? 8 : 9);
			cyc(3);
			chk1(usb_req, 1'b0);
			pulse(k[0] ? 9 : 8);
			wait_hi(1, 40, n);
			chk1(usb_ack && nm_ack, 1'b1);
			chk8({usb_req, nm_req, u_off, u_gate, n_off, n_gate, dev, 1'b0},
				{u[1], m[0], u[5], u[0], m[4], m[5], u[2], 1'b0});
			pulse(3 + (k + 1) % 5);
			cyc(2);
			chk1(deep, 1'b1);
			pulse(3 + k);
			cyc(1);
			chk8({deep, busy, usb_req, nm_req, 4'h0}, 8'h40);
			wait_hi(2, 40, n);
			chk1(n >= 4 && n <= 12, 1'b1);
		end
	endtask : t_wake

	initial begin
		repeat (8) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		t_regs();
		t_ce();
		t_lock();
		t_idle();
		t_bm();
		t_block();
		t_wake();
		test_done();
	end
endmodule : tb_top
